// File: car_defines.svh
`ifndef CAR_DEFINES_SVH
`define CAR_DEFINES_SVH
`define CAR_NUM_PORTS        8
`define CAR_PORT_SPACE_BYTES 32'h0000_1000
`define CAR_LEGACY_TOP       12'h0ff
`define CAR_EXT_BASE         12'h100
`define CAR_WIN_SIZE_BYTES   32'h0002_0000
`define CAR_WIN_MASK         32'hfffe_0000
`define CAR_OFF_BASE_LOW     12'h010
`define CAR_OFF_BASE_HIGH    12'h014
`define CAR_OFF_BUS_NUMS     12'h018
`define CAR_OFF_CMD_STATUS   12'h004
`define CAR_STAT_TGT_ABORT   27
`define CAR_SHADOW_BASE      12'h6c0
`define CAR_PM_LO            12'h040
`define CAR_PM_HI            12'h044
`define CAR_MSI_LO           12'h048
`define CAR_MSI_HI           12'h064
`define CAR_LINKCAP_LO       12'h068
`define CAR_LINKCAP_HI       12'h08c
`define CAR_DEVSPEC_LO       12'h1c0
`define CAR_DEVSPEC_HI       12'hfb0
`define CAR_EEPROM_LO        12'h260
`define CAR_EEPROM_HI        12'h26c
`define CAR_I2C_LO           12'h290
`define CAR_I2C_HI           12'h2c4
`define CAR_HP_LO            12'h1e0
`define CAR_HP_HI            12'h1ec
`define CAR_RST_BASE         32'h0000_0000
`define CAR_DEV_ID_CODE      16'h1234
`endif

// File: car_pkg.sv
package car_pkg;
  typedef enum logic [2:0] {
    CAR_CPL_NONE = 3'h0,
    CAR_CPL_OK   = 3'h1,
    CAR_CPL_UR   = 3'h2
  } car_cpl_t;
  typedef enum logic [1:0] {
    CAR_SRC_LEGACY = 2'h0,
    CAR_SRC_ENH    = 2'h1,
    CAR_SRC_MEM    = 2'h2
  } car_src_t;
  typedef enum logic [3:0] {
    CAR_ST_IDLE = 4'b0001,
    CAR_ST_ROUTE = 4'b0010,
    CAR_ST_REG   = 4'b0100,
    CAR_ST_DONE  = 4'b1000
  } car_state_t;
endpackage

// File: car_port_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "car_defines.svh"
// one port's register space; storage for fields this block owns
module car_port_regs #(
  parameter int PORT_IDX = 0
) (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  // access
  input  wire logic        sel_in,
  input  wire logic        wr_in,
  input  wire logic [11:0] off_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  be_in,
  input  wire logic        tgt_abort_set_in,
  input  wire logic [31:0] shadow_low_in,
  input  wire logic [31:0] shadow_high_in,
  input  wire logic        shadow_wr_in,
  input  wire logic [2:0]  up_port_in,
  output logic      [31:0] rdata_out,
  output logic      [7:0]  sec_bus_out,
  output logic      [7:0]  sub_bus_out,
  output logic      [31:0] base_low_out,
  output logic      [31:0] base_high_out
);
  logic [31:0] base_low_q, base_low_d, base_high_q, base_high_d;
  logic [31:0] bus_q, bus_d, scratch_q, scratch_d;
  logic        abort_q, abort_d;
  logic [31:0] shadow_q [0:15];
  logic [31:0] shadow_d [0:15];
  logic [31:0] wmask;
  logic        ext_ok;

  function automatic logic in_rng(input logic [11:0] o, lo, hi);
    return (o >= lo) && (o <= hi);
  endfunction

  always_comb begin
    wmask = {{8{be_in[3]}}, {8{be_in[2]}}, {8{be_in[1]}}, {8{be_in[0]}}};
    base_low_d  = base_low_q;
    base_high_d = base_high_q;
    bus_d       = bus_q;
    scratch_d   = scratch_q;
    abort_d     = abort_q | tgt_abort_set_in;
    for (int i = 0; i < 16; i++) shadow_d[i] = shadow_q[i];
    if (PORT_IDX == 0 && shadow_wr_in) begin
      shadow_d[{up_port_in, 1'b0}] = shadow_low_in;
      shadow_d[{up_port_in, 1'b1}] = shadow_high_in;
    end
    if (sel_in && wr_in) begin
      unique case (off_in)
        `CAR_OFF_BASE_LOW:
          base_low_d = (base_low_q & ~wmask) | (wdata_in & wmask);
        `CAR_OFF_BASE_HIGH:
          base_high_d = (base_high_q & ~wmask) | (wdata_in & wmask);
        `CAR_OFF_BUS_NUMS:
          bus_d = (bus_q & ~wmask) | (wdata_in & wmask);
        `CAR_OFF_CMD_STATUS:
          // set wins over clear; only a written one clears
          if (be_in[3] && wdata_in[`CAR_STAT_TGT_ABORT]
              && !tgt_abort_set_in) abort_d = 1'b0;
        default: begin
          if (PORT_IDX == 0 && off_in[11:6] == `CAR_SHADOW_BASE >> 6)
            shadow_d[off_in[5:2]] =
              (shadow_q[off_in[5:2]] & ~wmask) | (wdata_in & wmask);
          else if (in_rng(off_in, `CAR_DEVSPEC_LO, `CAR_DEVSPEC_HI)
                   && ext_ok)
            scratch_d = (scratch_q & ~wmask) | (wdata_in & wmask);
        end
      endcase
    end
  end

  // hot plug block exists only on ports 1..3; elsewhere reserved
  assign ext_ok = !in_rng(off_in, `CAR_HP_LO, `CAR_HP_HI) ||
                  (PORT_IDX >= 1 && PORT_IDX <= 3);

  always_comb begin
    rdata_out = 32'h0;
    unique case (off_in)
      12'h000: rdata_out = {`CAR_DEV_ID_CODE, 16'h0}; // arbitrary id
      // capability list flag is bit 20; every other unowned bit reads zero
      `CAR_OFF_CMD_STATUS: rdata_out = {4'h0, abort_q, 6'h0, 1'b1, 20'h0};
      `CAR_OFF_BASE_LOW:  rdata_out = base_low_q;
      `CAR_OFF_BASE_HIGH: rdata_out = base_high_q;
      `CAR_OFF_BUS_NUMS:  rdata_out = {8'h0, bus_q[23:0]};
      // capability ids at their fixed places
      `CAR_PM_LO:      rdata_out = {16'h0, 8'h48, 8'h01};
      `CAR_MSI_LO:     rdata_out = {16'h0, 8'h68, 8'h05};
      `CAR_LINKCAP_LO: rdata_out = {16'h0, 8'h90, 8'h10};
      default: begin
        // switch-wide blocks live in port 0 only
        if (PORT_IDX == 0 && off_in[11:6] == `CAR_SHADOW_BASE >> 6)
          rdata_out = shadow_q[off_in[5:2]];
        else if (PORT_IDX == 0 &&
                 (in_rng(off_in, `CAR_EEPROM_LO, `CAR_EEPROM_HI) ||
                  in_rng(off_in, `CAR_I2C_LO, `CAR_I2C_HI)))
          rdata_out = scratch_q;
        else if (in_rng(off_in, `CAR_DEVSPEC_LO, `CAR_DEVSPEC_HI) && ext_ok)
          rdata_out = scratch_q;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      base_low_q  <= `CAR_RST_BASE;
      base_high_q <= `CAR_RST_BASE;
      bus_q       <= 32'h0;
      scratch_q   <= 32'h0;
      abort_q     <= 1'b0;
      for (int i = 0; i < 16; i++) shadow_q[i] <= 32'h0;
    end else begin
      base_low_q  <= base_low_d;
      base_high_q <= base_high_d;
      bus_q       <= bus_d;
      scratch_q   <= scratch_d;
      abort_q     <= abort_d;
      for (int i = 0; i < 16; i++) shadow_q[i] <= shadow_d[i];
    end
  end

  assign sec_bus_out   = bus_q[15:8];
  assign sub_bus_out   = bus_q[23:16];
  assign base_low_out  = base_low_q;
  assign base_high_out = base_high_q;
endmodule
`default_nettype wire

// File: car_rc_model.sv
`timescale 1ns/1ps
`default_nettype none
// upstream requester: one request in flight, fields held until answered or 20 cycles pass
module car_rc_model (
  // clock
  input  wire logic        core_clk_in,
  // answers from the router
  input  wire logic        cpl_valid_in,
  input  wire logic        fwd_valid_in,
  // request toward the router
  output logic             req_valid_out,
  output logic [1:0]       req_src_out,
  output logic             req_type1_out,
  output logic             req_wr_out,
  output logic [7:0]       req_bus_out,
  output logic [4:0]       req_dev_out,
  output logic [11:0]      req_off_out,
  output logic [63:0]      req_addr_out,
  output logic [31:0]      req_wdata_out,
  output logic [3:0]       req_be_out
);
  initial begin
    req_valid_out = 1'b0;
    req_src_out = 2'h0;
    req_type1_out = 1'b0;
    req_wr_out = 1'b0;
    req_bus_out = 8'h0;
    req_dev_out = 5'h0;
    req_off_out = 12'h0;
    req_addr_out = 64'h0;
    req_wdata_out = 32'h0;
    req_be_out = 4'h0;
  end

  // valid is a one-cycle pulse; a held valid could be taken twice
  task automatic xfer(input logic [1:0] s, input logic t1, input logic w,
                      input logic [7:0] b, input logic [4:0] d,
                      input logic [11:0] o, input logic [63:0] a,
                      input logic [31:0] wd, input int gap);
    int n;
    n = 0;
    repeat (gap) @(posedge core_clk_in);
    @(posedge core_clk_in);
    req_valid_out <= 1'b1;
    req_src_out <= s;
    req_type1_out <= t1;
    req_wr_out <= w;
    req_bus_out <= b;
    req_dev_out <= d;
    req_off_out <= (s == 2'h0) ? {4'h0, o[7:0]} : o;
    req_addr_out <= a;
    req_wdata_out <= wd;
    req_be_out <= 4'hf;
    @(posedge core_clk_in);
    req_valid_out <= 1'b0;
    while (cpl_valid_in !== 1'b1 && fwd_valid_in !== 1'b1 && n < 20) begin
      @(posedge core_clk_in);
      n++;
    end
    // released fields must not look like a still-valid request
    req_bus_out <= ~b;
    req_off_out <= ~o;
    req_addr_out <= ~a;
    req_wdata_out <= ~wd;
  endtask
endmodule
`default_nettype wire

// File: car_router.sv
`timescale 1ns/1ps
`default_nettype none
`include "car_defines.svh"
module car_router (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  // request from the upstream link
  input  wire logic        req_valid_in,
  input  wire logic [1:0]  req_src_in,
  input  wire logic        req_type1_in,
  input  wire logic        req_wr_in,
  input  wire logic [7:0]  req_bus_in,
  input  wire logic [4:0]  req_dev_in,
  input  wire logic [11:0] req_off_in,
  input  wire logic [63:0] req_addr_in,
  input  wire logic [31:0] req_wdata_in,
  input  wire logic [3:0]  req_be_in,
  // strap and configuration
  input  wire logic [2:0]  up_port_in,
  input  wire logic [7:0]  int_bus_in,
  input  wire logic [3:0]  eeprom_base_wr_in,
  // completion
  output logic             cpl_valid_out,
  output logic [2:0]       cpl_status_out,
  output logic [31:0]      cpl_rdata_out,
  // forward toward a downstream link
  output logic             fwd_valid_out,
  output logic [2:0]       fwd_port_out,
  output logic             fwd_type1_out,
  output logic [7:0]       fwd_bus_out,
  output logic [4:0]       fwd_dev_out,
  output logic [11:0]      fwd_off_out,
  output logic             fwd_wr_out,
  output logic [31:0]      fwd_wdata_out,
  output logic [3:0]       fwd_be_out,
  // captured identity of the upstream port
  output logic [7:0]       up_bus_out,
  output logic [4:0]       up_dev_out
);
  car_pkg::car_state_t st_q, st_d;
  logic [7:0]  up_bus_q, up_bus_d;
  logic [4:0]  up_dev_q, up_dev_d;
  logic        cpl_v_q, cpl_v_d, fwd_v_q, fwd_v_d;
  logic [2:0]  cpl_s_q, cpl_s_d;
  logic [31:0] cpl_r_q, cpl_r_d;
  logic [2:0]  fport_q, fport_d;
  logic        ft1_q, ft1_d;
  logic [2:0]  tgt_q, tgt_d;
  logic        hit_q, hit_d;
  logic        tabort_q, tabort_d;
  logic        sel_v [0:7];
  logic [31:0] rd_v [0:7];
  logic [7:0]  sec_v [0:7];
  logic [7:0]  sub_v [0:7];
  logic [31:0] bl_v [0:7];
  logic [31:0] bh_v [0:7];
  logic [11:0] off_r;
  logic        shadow_wr;
  logic [63:0] base;
  logic [63:0] rel;

  // port n answers internal device n; the upstream bridge is the port named by up_port_in
  function automatic logic is_bridge_dev(input logic [4:0] d);
    return d < 5'(`CAR_NUM_PORTS);
  endfunction

  assign base = {bh_v[up_port_in], bl_v[up_port_in] & `CAR_WIN_MASK};
  assign rel  = req_addr_in - base;
  // mem path keeps the full 12-bit offset, legacy path only 8 bits
  assign off_r = (req_src_in == car_pkg::CAR_SRC_MEM) ? rel[11:0] :
                 (req_src_in == car_pkg::CAR_SRC_LEGACY) ?
                 {4'h0, req_off_in[7:0]} : req_off_in;

  genvar g;
  generate
    for (g = 0; g < `CAR_NUM_PORTS; g++) begin : g_port
      car_port_regs #(.PORT_IDX(g)) u_regs (
        .core_clk_in      (core_clk_in),
        .sys_rst_in       (sys_rst_in),
        .sel_in           (sel_v[g]),
        .wr_in            (req_wr_in && st_q == car_pkg::CAR_ST_REG),
        .off_in           (off_r),
        .wdata_in         (req_wdata_in),
        .be_in            (req_be_in),
        .tgt_abort_set_in (g == 0 && tabort_q),
        .shadow_low_in    (bl_v[up_port_in]),
        .shadow_high_in   (bh_v[up_port_in]),
        .shadow_wr_in     (g == 0 && shadow_wr),
        .up_port_in       (up_port_in),
        .rdata_out        (rd_v[g]),
        .sec_bus_out      (sec_v[g]),
        .sub_bus_out      (sub_v[g]),
        .base_low_out     (bl_v[g]),
        .base_high_out    (bh_v[g])
      );
      assign sel_v[g] = hit_q && tgt_q == 3'(g);
    end
  endgenerate

  // copy base pair one cycle after it was written
  assign shadow_wr = (st_q == car_pkg::CAR_ST_DONE) && hit_q && req_wr_in &&
                     tgt_q == up_port_in &&
                     (off_r == `CAR_OFF_BASE_LOW ||
                      off_r == `CAR_OFF_BASE_HIGH) ||
                     (|eeprom_base_wr_in);

  always_comb begin
    st_d = st_q;
    up_bus_d = up_bus_q;
    up_dev_d = up_dev_q;
    cpl_v_d = 1'b0;
    fwd_v_d = 1'b0;
    cpl_s_d = cpl_s_q;
    cpl_r_d = cpl_r_q;
    fport_d = fport_q;
    ft1_d = ft1_q;
    tgt_d = tgt_q;
    hit_d = hit_q;
    tabort_d = 1'b0;
    unique case (st_q)
      car_pkg::CAR_ST_IDLE: if (req_valid_in) begin
        hit_d = 1'b0;
        st_d = car_pkg::CAR_ST_ROUTE;
        if (!req_type1_in && req_src_in != car_pkg::CAR_SRC_MEM &&
            req_wr_in) begin
          up_bus_d = req_bus_in;
          up_dev_d = req_dev_in;
        end
      end
      car_pkg::CAR_ST_ROUTE: begin
        st_d = car_pkg::CAR_ST_DONE;
        cpl_s_d = car_pkg::CAR_CPL_UR;
        cpl_r_d = 32'h0;
        if (req_src_in == car_pkg::CAR_SRC_MEM) begin
          if (rel < 64'(`CAR_WIN_SIZE_BYTES)) begin
            cpl_s_d = car_pkg::CAR_CPL_OK;
            if (rel[16:15] == 2'h0) begin
              tgt_d = rel[14:12];
              hit_d = 1'b1;
              st_d = car_pkg::CAR_ST_REG;
            end else begin
              tabort_d = 1'b1;
            end
          end
        end else if (!req_type1_in) begin
          tgt_d = up_port_in;
          hit_d = !(req_src_in == car_pkg::CAR_SRC_ENH &&
                    req_off_in >= `CAR_DEVSPEC_LO);
          cpl_s_d = hit_d ? car_pkg::CAR_CPL_OK : car_pkg::CAR_CPL_UR;
          st_d = hit_d ? car_pkg::CAR_ST_REG : car_pkg::CAR_ST_DONE;
        end else if (req_bus_in == int_bus_in) begin
          if (is_bridge_dev(req_dev_in)) begin
            tgt_d = req_dev_in[2:0];
            hit_d = !(req_src_in == car_pkg::CAR_SRC_ENH &&
                      req_off_in >= `CAR_DEVSPEC_LO);
            cpl_s_d = hit_d ? car_pkg::CAR_CPL_OK : car_pkg::CAR_CPL_UR;
            st_d = hit_d ? car_pkg::CAR_ST_REG : car_pkg::CAR_ST_DONE;
          end
        end else begin
          for (int p = `CAR_NUM_PORTS - 1; p >= 0; p--) begin
            if (p != int'(up_port_in) && req_bus_in >= sec_v[p] &&
                req_bus_in <= sub_v[p] && sec_v[p] != 8'h0) begin
              fport_d = 3'(p);
              if (req_bus_in == sec_v[p]) begin
                ft1_d = 1'b0;
                cpl_s_d = (req_dev_in == 5'h0) ? car_pkg::CAR_CPL_NONE :
                          car_pkg::CAR_CPL_UR;
              end else begin
                ft1_d = 1'b1;
                cpl_s_d = car_pkg::CAR_CPL_NONE;
              end
            end
          end
        end
      end
      car_pkg::CAR_ST_REG: begin
        cpl_r_d = req_wr_in ? 32'h0 : rd_v[tgt_q];
        st_d = car_pkg::CAR_ST_DONE;
      end
      car_pkg::CAR_ST_DONE: begin
        // a forward is issued instead of a completion
        if (cpl_s_q == car_pkg::CAR_CPL_NONE) fwd_v_d = 1'b1;
        else cpl_v_d = 1'b1;
        st_d = car_pkg::CAR_ST_IDLE;
      end
      default: st_d = car_pkg::CAR_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      st_q <= car_pkg::CAR_ST_IDLE;
      up_bus_q <= 8'h0;
      up_dev_q <= 5'h0;
      cpl_v_q <= 1'b0;
      fwd_v_q <= 1'b0;
      cpl_s_q <= 3'h0;
      cpl_r_q <= 32'h0;
      fport_q <= 3'h0;
      ft1_q <= 1'b0;
      tgt_q <= 3'h0;
      hit_q <= 1'b0;
      tabort_q <= 1'b0;
    end else begin
      st_q <= st_d;
      up_bus_q <= up_bus_d;
      up_dev_q <= up_dev_d;
      cpl_v_q <= cpl_v_d;
      fwd_v_q <= fwd_v_d;
      cpl_s_q <= cpl_s_d;
      cpl_r_q <= cpl_r_d;
      fport_q <= fport_d;
      ft1_q <= ft1_d;
      tgt_q <= tgt_d;
      hit_q <= hit_d;
      tabort_q <= tabort_d;
    end
  end

  // forward fields are held stable by the requester until the pulse
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      fwd_bus_out <= 8'h0;
      fwd_dev_out <= 5'h0;
      fwd_off_out <= 12'h0;
      fwd_wr_out <= 1'b0;
      fwd_wdata_out <= 32'h0;
      fwd_be_out <= 4'h0;
    end else begin
      fwd_bus_out <= req_bus_in;
      fwd_dev_out <= req_dev_in;
      fwd_off_out <= req_off_in;
      fwd_wr_out <= req_wr_in;
      fwd_wdata_out <= req_wdata_in;
      fwd_be_out <= req_be_in;
    end
  end

  assign cpl_valid_out = cpl_v_q;
  assign cpl_status_out = cpl_s_q;
  assign cpl_rdata_out = cpl_r_q;
  assign fwd_valid_out = fwd_v_q;
  assign fwd_port_out = fport_q;
  assign fwd_type1_out = ft1_q;
  assign up_bus_out = up_bus_q;
  assign up_dev_out = up_dev_q;

  property p_ur_internal;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (st_q == car_pkg::CAR_ST_ROUTE && req_src_in != car_pkg::CAR_SRC_MEM &&
     req_type1_in && req_bus_in == int_bus_in && !is_bridge_dev(req_dev_in))
    |=> ##1 (cpl_valid_out && cpl_status_out == car_pkg::CAR_CPL_UR);
  endproperty
  a_ur_internal: assert property (p_ur_internal)
    else $error("missing unsupported completion");

  property p_gap_zero;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (st_q == car_pkg::CAR_ST_ROUTE && req_src_in == car_pkg::CAR_SRC_MEM &&
     rel < 64'(`CAR_WIN_SIZE_BYTES) && rel[16:15] != 2'h0)
    |=> ##1 (cpl_valid_out && cpl_rdata_out == 32'h0 &&
             cpl_status_out == car_pkg::CAR_CPL_OK);
  endproperty
  a_gap_zero: assert property (p_gap_zero)
    else $error("gap access not zero ok");

  property p_one_out;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    !(cpl_valid_out && fwd_valid_out);
  endproperty
  a_one_out: assert property (p_one_out)
    else $error("completion and forward together");

  sequence s_answer;
    cpl_valid_out || fwd_valid_out;
  endsequence

  property p_answer_time;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (st_q == car_pkg::CAR_ST_IDLE && req_valid_in) |-> ##[3:4] s_answer;
  endproperty
  a_answer_time: assert property (p_answer_time)
    else $error("no answer within four cycles");

  property p_cap_up;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (st_q == car_pkg::CAR_ST_IDLE && req_valid_in && !req_type1_in &&
     req_src_in != car_pkg::CAR_SRC_MEM && req_wr_in)
    |=> (up_bus_out == $past(req_bus_in) && up_dev_out == $past(req_dev_in));
  endproperty
  a_cap_up: assert property (p_cap_up)
    else $error("upstream bus and device not captured");

  property p_fwd_type0;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (fwd_valid_out && !fwd_type1_out) |-> (fwd_dev_out == 5'h0);
  endproperty
  a_fwd_type0: assert property (p_fwd_type0)
    else $error("type 0 forward with nonzero device");
endmodule
`default_nettype wire

// File: tb_car_router.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  tests_run++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); \
  end
module tb_car_router;
  localparam logic [20:0] MH   = {1'b1, 3'h7, 17'h0};
  localparam logic [52:0] MFWD = {1'b1, 3'h7, 17'h1ffff, 32'h0};
  localparam logic [63:0] BASE = 64'h0000_0001_4002_0000;
  localparam logic [2:0]  OK   = car_pkg::CAR_CPL_OK;
  localparam logic [2:0]  UR   = car_pkg::CAR_CPL_UR;
  logic        core_clk_in, sys_rst_in, req_valid_in, req_type1_in;
  logic        req_wr_in, cpl_valid_out, fwd_valid_out, fwd_type1_out;
  logic        fwd_wr_out;
  logic [1:0]  req_src_in;
  logic [2:0]  up_port_in, cpl_status_out, fwd_port_out;
  logic [3:0]  req_be_in, eeprom_base_wr_in, fwd_be_out;
  logic [4:0]  req_dev_in, fwd_dev_out, up_dev_out;
  logic [7:0]  req_bus_in, int_bus_in, fwd_bus_out, up_bus_out;
  logic [11:0] req_off_in, fwd_off_out;
  logic [31:0] req_wdata_in, cpl_rdata_out, fwd_wdata_out;
  logic [63:0] req_addr_in;
  logic [52:0] exp_q[$], msk_q[$], exp_sig, got_sig;
  logic [31:0] dv[8];
  int          fails, tests_run, seed;

  car_router car_router_inst (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .req_valid_in(req_valid_in),
    .req_src_in(req_src_in), .req_type1_in(req_type1_in),
    .req_wr_in(req_wr_in), .req_bus_in(req_bus_in),
    .req_dev_in(req_dev_in), .req_off_in(req_off_in),
    .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
    .req_be_in(req_be_in), .up_port_in(up_port_in),
    .int_bus_in(int_bus_in), .eeprom_base_wr_in(eeprom_base_wr_in),
    .cpl_valid_out(cpl_valid_out), .cpl_status_out(cpl_status_out),
    .cpl_rdata_out(cpl_rdata_out), .fwd_valid_out(fwd_valid_out),
    .fwd_port_out(fwd_port_out), .fwd_type1_out(fwd_type1_out),
    .fwd_bus_out(fwd_bus_out), .fwd_dev_out(fwd_dev_out),
    .fwd_off_out(fwd_off_out), .fwd_wr_out(fwd_wr_out),
    .fwd_wdata_out(fwd_wdata_out), .fwd_be_out(fwd_be_out),
    .up_bus_out(up_bus_out), .up_dev_out(up_dev_out));

  car_rc_model car_rc_model_inst (.core_clk_in(core_clk_in),
    .cpl_valid_in(cpl_valid_out), .fwd_valid_in(fwd_valid_out),
    .req_valid_out(req_valid_in), .req_src_out(req_src_in),
    .req_type1_out(req_type1_in), .req_wr_out(req_wr_in),
    .req_bus_out(req_bus_in), .req_dev_out(req_dev_in),
    .req_off_out(req_off_in), .req_addr_out(req_addr_in),
    .req_wdata_out(req_wdata_in), .req_be_out(req_be_in));

  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end

  function automatic logic [52:0] cpl(logic [2:0] st, logic [31:0] rd);
    return {1'b0, st, 17'h0, rd};
  endfunction

  function automatic logic [52:0] fwd(logic t1, logic [7:0] b, logic [4:0] d);
    return {1'b1, 3'h0, t1, 3'h4, b, d, 32'h0};
  endfunction

  task automatic rq(input logic [1:0] s, input logic t1, input logic w,
                    input logic [7:0] b, input logic [4:0] d,
                    input logic [11:0] o, input logic [63:0] a,
                    input logic [31:0] wd, input logic [52:0] e,
                    input logic [52:0] m);
    int g;
    g = $random(seed) & 1;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    car_rc_model_inst.xfer(s, t1, w, b, d, o, a, wd, g);
  endtask

  task automatic mem(input logic w, input logic [31:0] o,
                     input logic [31:0] wd, input logic [31:0] rd,
                     input logic [31:0] rm);
    rq(2'h2, 1'b0, w, 8'h0, 5'h0, o[11:0], BASE + 64'(o), wd,
       cpl(OK, rd), {MH, rm});
  endtask

  // one note per answer; a missing or extra answer shows as a mismatch
  always @(posedge core_clk_in) begin
    if (cpl_valid_out === 1'b1 || fwd_valid_out === 1'b1) begin
      exp_sig = exp_q.size() ? exp_q.pop_front() : '1;
      got_sig = {fwd_valid_out, cpl_status_out, fwd_type1_out, fwd_port_out,
                 fwd_bus_out, fwd_dev_out, cpl_rdata_out};
      got_sig = got_sig & (msk_q.size() ? msk_q.pop_front() : '1);
      `CHK("answer", exp_sig, got_sig)
    end
  end

  task automatic results;
    `CHK("pending answers", 0, exp_q.size())
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #(40 * 4000);
    fails++;
    results;
  end

  initial begin
    seed = 32'h1d19;
    sys_rst_in = 1'b1;
    up_port_in = 3'h2;
    int_bus_in = 8'h01;
    eeprom_base_wr_in = 4'h0;
    repeat (20) @(posedge core_clk_in);
    `CHK("up_bus in reset", 8'h0, up_bus_out)
    sys_rst_in <= 1'b0;
    // type 0 writes land in the upstream port and name it
    rq(2'h0, 1'b0, 1'b1, 8'h05, 5'h03, 12'h010, 64'h0, BASE[31:0],
       cpl(OK, 32'h0), {MH, 32'h0});
    #1;
    `CHK("up_bus", 8'h05, up_bus_out)
    `CHK("up_dev", 5'h03, up_dev_out)
    rq(2'h0, 1'b0, 1'b1, 8'h05, 5'h03, 12'h014, 64'h0, BASE[63:32],
       cpl(OK, 32'h0), {MH, 32'h0});
    rq(2'h0, 1'b0, 1'b0, 8'h05, 5'h03, 12'h010, 64'h0, 32'h0,
       cpl(OK, BASE[31:0]), {MH, 32'hffffffff});
    // upstream is port 2, so its shadow pair sits 16 bytes up
    mem(1'b0, 32'h6d0, 32'h0, BASE[31:0], 32'hffffffff);
    mem(1'b0, 32'h6d4, 32'h0, BASE[63:32], 32'hffffffff);
    rq(2'h0, 1'b1, 1'b1, 8'h01, 5'h04, 12'h018, 64'h0, 32'h0014_1001,
       cpl(OK, 32'h0), {MH, 32'h0});
    rq(2'h0, 1'b1, 1'b0, 8'h01, 5'h04, 12'h018, 64'h0, 32'h0,
       cpl(OK, 32'h0014_1000), {MH, 32'h00ffff00});
    rq(2'h1, 1'b1, 1'b0, 8'h01, 5'h04, 12'h018, 64'h0, 32'h0,
       cpl(OK, 32'h0014_1000), {MH, 32'h00ffff00});
    rq(2'h1, 1'b1, 1'b0, 8'h01, 5'h04, 12'h1c0, 64'h0, 32'h0,
       cpl(UR, 32'h0), {MH, 32'h0});
    rq(2'h0, 1'b1, 1'b0, 8'h01, 5'h09, 12'h000, 64'h0, 32'h0,
       cpl(UR, 32'h0), {MH, 32'h0});
    mem(1'b0, 32'h4018, 32'h0, 32'h0014_1000, 32'h00ffff00);
    rq(2'h0, 1'b1, 1'b0, 8'h10, 5'h00, 12'h000, 64'h0, 32'h0,
       fwd(1'b0, 8'h10, 5'h00), MFWD);
    rq(2'h0, 1'b1, 1'b1, 8'h10, 5'h03, 12'h000, 64'h0, 32'h0,
       cpl(UR, 32'h0), {MH, 32'h0});
    rq(2'h0, 1'b1, 1'b0, 8'h12, 5'h07, 12'h000, 64'h0, 32'h0,
       fwd(1'b1, 8'h12, 5'h07), MFWD);
    for (int p = 0; p < 8; p++) begin
      dv[p] = $random(seed);
      mem(1'b1, {17'h0, p[2:0], 12'h1c0}, dv[p], 32'h0, 32'h0);
    end
    for (int p = 0; p < 8; p++) begin
      mem(1'b0, {17'h0, p[2:0], 12'h1c0}, 32'h0, dv[p], '1);
    end
    // slots past port 7 read zero and flag a target abort in port 0
    mem(1'b0, 32'h8000, 32'h0, 32'h0, 32'hffffffff);
    mem(1'b0, 32'h1fffc, 32'h0, 32'h0, 32'hffffffff);
    mem(1'b0, 32'h004, 32'h0, 32'h0810_0000, 32'hffffffff);
    mem(1'b1, 32'h004, 32'h0, 32'h0, 32'h0);
    mem(1'b0, 32'h004, 32'h0, 32'h0800_0000, 32'h0800_0000);
    mem(1'b1, 32'h004, 32'h0800_0000, 32'h0, 32'h0);
    mem(1'b0, 32'h004, 32'h0, 32'h0, 32'h0800_0000);
    // spoil a shadow, then an image load must copy the base pair back into it
    mem(1'b1, 32'h6d0, 32'h0, 32'h0, 32'h0);
    @(posedge core_clk_in);
    eeprom_base_wr_in <= 4'h1;
    @(posedge core_clk_in);
    eeprom_base_wr_in <= 4'h0;
    mem(1'b0, 32'h6d0, 32'h0, BASE[31:0], 32'hffffffff);
    repeat (4) @(posedge core_clk_in);
    results;
  end
endmodule
`default_nettype wire
